// ---- rtl/sdcs_consts.vh ----
`ifndef SDCS_CONSTS_VH
`define SDCS_CONSTS_VH
// Register byte offsets
`define SDCS_OFF_CTL 12'h000
`define SDCS_OFF_TIM 12'h004
`define SDCS_OFF_EXT 12'h008
`define SDCS_OFF_SPC 12'h00c
`define SDCS_OFF_STAT 12'h010
// Control register fields
`define SDCS_CTL_REFRESH_ENABLE 0
`define SDCS_CTL_TCL 1
`define SDCS_CTL_BSZ 2
`define SDCS_CTL_CSZ 4:3
`define SDCS_CTL_RSZ 6:5
`define SDCS_CTL_WID 8:7
`define SDCS_CTL_MEMORY_TYPE_SELECT 12:9
`define SDCS_CTL_MRSGO 13
`define SDCS_CTL_W 13
`define SDCS_CTL_RST 14'h0000
// Refresh timer fields
`define SDCS_TIM_PER 11:0
`define SDCS_TIM_XRF 13:12
`define SDCS_TIM_RST 14'h05dc
// Timing register fields, 4 bits each
`define SDCS_EXT_TRC 3:0
`define SDCS_EXT_ACTIVATE_TO_RW_COUNT 7:4
`define SDCS_EXT_TRP 11:8
`define SDCS_EXT_ACTIVE_TIME_COUNT 15:12
`define SDCS_EXT_BANK_TO_BANK_COUNT 19:16
`define SDCS_EXT_TWR 23:20
`define SDCS_EXT_PRECHARGE_HIZ_COUNT 27:24
`define SDCS_EXT_RST 32'h0111_3242
// Command spacing fields, 4 bits each
`define SDCS_SPC_READ_TO_READ_COUNT 3:0
`define SDCS_SPC_RD2CL 7:4
`define SDCS_SPC_READ_TO_WRITE_COUNT 11:8
`define SDCS_SPC_MASK 15:12
`define SDCS_SPC_WRITE_TO_WRITE_COUNT 19:16
`define SDCS_SPC_WR2CL 23:20
`define SDCS_SPC_WRITE_TO_READ_COUNT 27:24
`define SDCS_SPC_RST 28'h0101_313
// Commands {ras_n, cas_n, we_n}
`define SDCS_CMD_NOP 3'h7
`define SDCS_CMD_ACT 3'h3
`define SDCS_CMD_RD 3'h5
`define SDCS_CMD_WR 3'h4
`define SDCS_CMD_PRE 3'h2
`define SDCS_CMD_REF 3'h1
`define SDCS_CMD_MRS 3'h0
// Spacing counter slots
`define SDCS_K_ACT 0
`define SDCS_K_RD 1
`define SDCS_K_WR 2
`define SDCS_K_PRE 3
`define SDCS_K_REF 4
`define SDCS_NK 5
// Mode values and geometry
`define SDCS_MRS_CL3 20'h00032
`define SDCS_MRS_CL2 20'h00022
`define SDCS_ROW_BASE 5'd11
`define SDCS_COL_BASE 5'd8
`define SDCS_A10_PIN 10
`define SDCS_BURST 5'd4
`define SDCS_CAP_OFS 3'd4
`define SDCS_NREG 4
`define SDCS_PINS 20
`endif

// ---- rtl/sdcs_top.v ----
// Behaviour
// - Activate drives row plus bank pins only
// - Column cycles keep bank pins valid
// - Latch line 10 at activate, low at rd/wr
// - Pin shift set by bus width and column size
// - Bank bits above row pins, one or two
// - Refresh only when refresh_enable set
// - Refresh selects the regions set in memory type select
// - Close-all always precedes refresh
// - Refreshes paced by programmed refresh period
// - Refresh high priority, current transfer finishes
// - Counter expiry adds extra refreshes
// - Mode load 0032h or 0022h by latency
// - Burst four, sequential, latency field 01x
// - Refresh to activate/mode/refresh spacing
// - Activate to rw, close to activate spacing
// - Read capture at latency plus two
// - Row open time, bank to bank spacing
// - Write recovery and close to high-z
// - Read spacing and mask before write
// - Write to write, close, read spacing
// - Four-word read, extras discarded
// - Pending access may cut read burst
// - Page stays open when idle
//
// The register addresses and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/10ps
`include "sdcs_consts.vh"
module sdcs_top (
    // Clock and reset
    input wire ref_clk,
    input wire nrst,
    // AHB-Lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    // Access requests
    input wire req_valid,
    input wire req_write,
    input wire [1:0] req_region,
    input wire [31:0] req_addr,
    input wire [31:0] req_wdata,
    output reg req_ready,
    output reg rd_valid,
    output reg [31:0] rd_data,
    // SDRAM pins
    output reg [`SDCS_NREG-1:0] sd_cs_n,
    output reg sd_ras_n,
    output reg sd_cas_n,
    output reg sd_we_n,
    output reg [`SDCS_PINS-1:0] sd_addr,
    output reg [`SDCS_PINS-1:0] sd_addr_oe,
    output reg [3:0] sd_be_n,
    output reg [31:0] sd_dq_o,
    output reg sd_dq_oe,
    input wire [31:0] sd_dq_i
);

localparam ST_IDLE = 2'h0;
localparam ST_CLALL = 2'h1;
localparam ST_REF = 2'h2;
localparam ST_MRS = 2'h3;

function [`SDCS_PINS-1:0] fmask;
    input [4:0] n;
    begin
        fmask = ~({`SDCS_PINS{1'b1}} << n);
    end
endfunction

// Row size code 10 is treated like 11
function [4:0] frows;
    input [1:0] rsz;
    begin
        frows = `SDCS_ROW_BASE + {3'h0, rsz[1], rsz[0] & ~rsz[1]};
        if (rsz == 2'h1) begin
            frows = `SDCS_ROW_BASE + 5'd1;
        end
    end
endfunction

function ge;
    input [4:0] since;
    input [3:0] fld;
    input [4:0] extra;
    begin
        ge = since >= ({1'b0, fld} + extra);
    end
endfunction

reg [`SDCS_CTL_W:0] ctl_q;
reg [13:0] tim_q;
reg [31:0] ext_q;
reg [27:0] spc_q;
reg ap_q, apw_q;
reg [11:0] apa_q;
reg [1:0] st_q, st_d;
reg mrs_pend_q;
reg [11:0] ref_cnt_q;
reg [2:0] ref_left_q;
reg page_vld_q;
reg [1:0] page_reg_q;
reg [`SDCS_PINS-1:0] page_rb_q;
reg [4:0] since_q [0:`SDCS_NK-1];
reg [4:0] hi_cnt_q;
reg [7:0] rd_pipe_q;
reg [31:0] dq_s1_q, dq_s2_q;
reg [2:0] cmd_d;
reg [`SDCS_NREG-1:0] cs_d;
reg [`SDCS_PINS-1:0] addr_d, aoe_d;
reg [`SDCS_NK-1:0] issue;
reg be_lo_d;

wire [1:0] ws = ctl_q[`SDCS_CTL_WID];
wire [4:0] nc = `SDCS_COL_BASE + {3'h0, ctl_q[`SDCS_CTL_CSZ]};
wire [4:0] nr = frows(ctl_q[`SDCS_CTL_RSZ]);
wire [4:0] nrb = nr + {4'h0, 1'b1} + {4'h0, ctl_q[`SDCS_CTL_BSZ]};
wire [`SDCS_NREG-1:0] sd_regions = ctl_q[`SDCS_CTL_MEMORY_TYPE_SELECT];
wire [31:0] wa = req_addr >> ws;
wire [31:0] wa_row = wa >> nc;
wire [`SDCS_PINS-1:0] rb_cur = wa_row[`SDCS_PINS-1:0] & fmask(nrb);
wire [`SDCS_PINS-1:0] bank_pins = page_rb_q & fmask(nrb) & ~fmask(nr);
wire hit = page_vld_q && page_reg_q == req_region && page_rb_q == rb_cur;
wire [2:0] cap_idx = {2'h0, ctl_q[`SDCS_CTL_TCL]} + `SDCS_CAP_OFS;
wire rd_busy = |rd_pipe_q[5:0];
wire [4:0] s_act = since_q[`SDCS_K_ACT];
wire [4:0] s_rd = since_q[`SDCS_K_RD];
wire [4:0] s_wr = since_q[`SDCS_K_WR];
wire [4:0] s_pre = since_q[`SDCS_K_PRE];
wire [4:0] s_ref = since_q[`SDCS_K_REF];

// Row open time before any close
wire close_ok = ge(s_act, ext_q[`SDCS_EXT_ACTIVE_TIME_COUNT], 5'd1) && ge(s_wr, ext_q[`SDCS_EXT_TWR], 5'd1)
    && ge(s_rd, spc_q[`SDCS_SPC_RD2CL], 5'd1) && ge(s_wr, spc_q[`SDCS_SPC_WR2CL], 5'd1);
// Close to activate, mode or refresh
wire pre_ref_ok = ge(s_pre, ext_q[`SDCS_EXT_TRP], 5'd1) && ge(s_ref, ext_q[`SDCS_EXT_TRC], 5'd1);
wire act_ok = pre_ref_ok && ge(s_act, ext_q[`SDCS_EXT_BANK_TO_BANK_COUNT], 5'd2);
wire rd_ok = ge(s_act, ext_q[`SDCS_EXT_ACTIVATE_TO_RW_COUNT], 5'd1) && ge(s_rd, spc_q[`SDCS_SPC_READ_TO_READ_COUNT], 5'd1)
    && ge(s_wr, spc_q[`SDCS_SPC_WRITE_TO_READ_COUNT], 5'd1);
// Read to write and mask hold
wire wr_ok = ge(s_act, ext_q[`SDCS_EXT_ACTIVATE_TO_RW_COUNT], 5'd1) && ge(s_rd, spc_q[`SDCS_SPC_READ_TO_WRITE_COUNT], 5'd1)
    && ge(hi_cnt_q, spc_q[`SDCS_SPC_MASK], 5'd1) && ge(s_wr, spc_q[`SDCS_SPC_WRITE_TO_WRITE_COUNT], 5'd1)
    && ge(s_pre, ext_q[`SDCS_EXT_PRECHARGE_HIZ_COUNT], 5'd1);

assign hreadyout = 1'b1;
assign hresp = 1'b0;

function [31:0] fread;
    input [11:0] a;
    begin
        case (a)
            `SDCS_OFF_CTL: fread = {18'h0, ctl_q};
            `SDCS_OFF_TIM: fread = {18'h0, tim_q};
            `SDCS_OFF_EXT: fread = ext_q;
            `SDCS_OFF_SPC: fread = {4'h0, spc_q};
            `SDCS_OFF_STAT: fread = {11'h0, st_q, page_vld_q, ref_left_q, mrs_pend_q, ref_cnt_q, 2'h0};
            default: fread = 32'h0;
        endcase
    end
endfunction

// AHB slave, zero wait states
always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        ap_q <= 1'b0;
        apw_q <= 1'b0;
        apa_q <= 12'h000;
        hrdata <= 32'h0;
        ctl_q <= `SDCS_CTL_RST;
        tim_q <= `SDCS_TIM_RST;
        ext_q <= `SDCS_EXT_RST;
        spc_q <= `SDCS_SPC_RST;
    end else begin
        ap_q <= hsel && htrans[1] && hready;
        apw_q <= hwrite;
        apa_q <= haddr[11:0];
        if (hsel && htrans[1] && hready && !hwrite) begin
            hrdata <= fread(haddr[11:0]);
        end
        if (ap_q && apw_q) begin
            case (apa_q)
                `SDCS_OFF_CTL: ctl_q <= {1'b0, hwdata[`SDCS_CTL_W-1:0]};
                `SDCS_OFF_TIM: tim_q <= hwdata[13:0];
                `SDCS_OFF_EXT: ext_q <= hwdata;
                `SDCS_OFF_SPC: spc_q <= hwdata[27:0];
                default: ctl_q <= ctl_q;
            endcase
        end
    end
end

// Command scheduler
always @* begin
    st_d = st_q;
    cmd_d = `SDCS_CMD_NOP;
    cs_d = {`SDCS_NREG{1'b1}};
    addr_d = {`SDCS_PINS{1'b0}};
    aoe_d = {`SDCS_PINS{1'b0}};
    issue = {`SDCS_NK{1'b0}};
    req_ready = 1'b0;
    be_lo_d = 1'b0;
    case (st_q)
        ST_IDLE: begin
            if (mrs_pend_q || ref_left_q != 3'h0) begin
                if (!rd_busy) begin
                    st_d = ST_CLALL;
                end
            end else if (req_valid) begin
                cs_d[req_region] = 1'b0;
                if (hit && (req_write ? wr_ok : rd_ok)) begin
                    addr_d = (wa[`SDCS_PINS-1:0] & fmask(nc) & ~(20'h1 << `SDCS_A10_PIN)) | bank_pins;
                    aoe_d = fmask(nrb);
                    cmd_d = req_write ? `SDCS_CMD_WR : `SDCS_CMD_RD;
                    issue[`SDCS_K_RD] = !req_write;
                    issue[`SDCS_K_WR] = req_write;
                    be_lo_d = 1'b1;
                    req_ready = 1'b1;
                end else if (page_vld_q && !hit && close_ok) begin
                    cs_d = {`SDCS_NREG{1'b1}};
                    cs_d[page_reg_q] = 1'b0;
                    addr_d = bank_pins;
                    aoe_d = fmask(nrb);
                    cmd_d = `SDCS_CMD_PRE;
                    issue[`SDCS_K_PRE] = 1'b1;
                end else if (!page_vld_q && act_ok) begin
                    // Bank bits sit above the row
                    addr_d = rb_cur;
                    aoe_d = fmask(nrb);
                    cmd_d = `SDCS_CMD_ACT;
                    issue[`SDCS_K_ACT] = 1'b1;
                end else begin
                    cs_d = {`SDCS_NREG{1'b1}};
                end
            end
        end
        ST_CLALL: begin
            if (close_ok) begin
                cs_d = ~sd_regions;
                addr_d[`SDCS_A10_PIN] = 1'b1;
                aoe_d[`SDCS_A10_PIN] = 1'b1;
                cmd_d = `SDCS_CMD_PRE;
                issue[`SDCS_K_PRE] = 1'b1;
                st_d = mrs_pend_q ? ST_MRS : ST_REF;
            end
        end
        ST_REF: begin
            if (pre_ref_ok) begin
                cs_d = ~sd_regions;
                cmd_d = `SDCS_CMD_REF;
                issue[`SDCS_K_REF] = 1'b1;
                if (ref_left_q <= 3'h1) begin
                    st_d = ST_IDLE;
                end
            end
        end
        ST_MRS: begin
            if (pre_ref_ok) begin
                cs_d = ~sd_regions;
                addr_d = ctl_q[`SDCS_CTL_TCL] ? `SDCS_MRS_CL3 : `SDCS_MRS_CL2;
                aoe_d = {`SDCS_PINS{1'b1}};
                cmd_d = `SDCS_CMD_MRS;
                st_d = ST_IDLE;
            end
        end
        default: st_d = ST_IDLE;
    endcase
end

// Saturating spacing counters, 1 on the edge after a command
genvar gk;
generate
    for (gk = 0; gk < `SDCS_NK; gk = gk + 1) begin : g_since
        always @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
                since_q[gk] <= 5'h1f;
            end else if (issue[gk]) begin
                since_q[gk] <= 5'h01;
            end else if (since_q[gk] != 5'h1f) begin
                since_q[gk] <= since_q[gk] + 5'h01;
            end
        end
    end
endgenerate

// Sequencer state, refresh timer, page
always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        st_q <= ST_IDLE;
        mrs_pend_q <= 1'b0;
        ref_cnt_q <= 12'h000;
        ref_left_q <= 3'h0;
        page_vld_q <= 1'b0;
        page_reg_q <= 2'h0;
        page_rb_q <= {`SDCS_PINS{1'b0}};
    end else begin
        st_q <= st_d;
        if (ap_q && apw_q && apa_q == `SDCS_OFF_CTL && hwdata[`SDCS_CTL_MRSGO]) begin
            mrs_pend_q <= 1'b1;
        end else if (st_q == ST_MRS && st_d == ST_IDLE) begin
            mrs_pend_q <= 1'b0;
        end
        if (!ctl_q[`SDCS_CTL_REFRESH_ENABLE]) begin
            ref_cnt_q <= tim_q[`SDCS_TIM_PER];
        end else if (ref_cnt_q == 12'h000) begin
            ref_cnt_q <= tim_q[`SDCS_TIM_PER];
        end else begin
            ref_cnt_q <= ref_cnt_q - 12'h001;
        end
        if (ctl_q[`SDCS_CTL_REFRESH_ENABLE] && ref_cnt_q == 12'h000) begin
            ref_left_q <= 3'h1 + {1'b0, tim_q[`SDCS_TIM_XRF]};
        end else if (issue[`SDCS_K_REF]) begin
            ref_left_q <= ref_left_q - 3'h1;
        end
        // Only a miss or close-all ends the page
        if (issue[`SDCS_K_ACT]) begin
            page_vld_q <= 1'b1;
            page_reg_q <= req_region;
            page_rb_q <= rb_cur;
        end else if (issue[`SDCS_K_PRE]) begin
            page_vld_q <= 1'b0;
        end
    end
end

// Registered pins and read capture
always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        sd_cs_n <= {`SDCS_NREG{1'b1}};
        {sd_ras_n, sd_cas_n, sd_we_n} <= `SDCS_CMD_NOP;
        sd_addr <= {`SDCS_PINS{1'b0}};
        sd_addr_oe <= {`SDCS_PINS{1'b0}};
        sd_be_n <= 4'hf;
        sd_dq_o <= 32'h0;
        sd_dq_oe <= 1'b0;
        hi_cnt_q <= 5'h1f;
        rd_pipe_q <= 8'h00;
        dq_s1_q <= 32'h0;
        dq_s2_q <= 32'h0;
        rd_valid <= 1'b0;
        rd_data <= 32'h0;
    end else begin
        sd_cs_n <= cs_d;
        {sd_ras_n, sd_cas_n, sd_we_n} <= cmd_d;
        sd_addr <= addr_d;
        sd_addr_oe <= aoe_d;
        // Unmask the four read beats; writes carry one word, rest masked
        sd_be_n <= (be_lo_d || s_rd < `SDCS_BURST) ? 4'h0 : 4'hf;
        sd_dq_o <= req_wdata;
        sd_dq_oe <= issue[`SDCS_K_WR];
        if (be_lo_d || s_rd < `SDCS_BURST) begin
            hi_cnt_q <= 5'h00;
        end else if (hi_cnt_q != 5'h1f) begin
            hi_cnt_q <= hi_cnt_q + 5'h01;
        end
        rd_pipe_q <= {rd_pipe_q[6:0], issue[`SDCS_K_RD]};
        dq_s1_q <= sd_dq_i;
        dq_s2_q <= dq_s1_q;
        rd_valid <= rd_pipe_q[cap_idx];
        if (rd_pipe_q[cap_idx]) begin
            rd_data <= dq_s2_q;
        end
    end
end

endmodule // sdcs_top

// ---- tb/sdcs_properties.sv ----
`timescale 1ns/10ps
`include "sdcs_consts.vh"
module sdcs_properties (
    // Clock and reset
    input wire ref_clk,
    input wire nrst,
    // Observed outputs
    input wire rd_valid,
    input wire [`SDCS_NREG-1:0] sd_cs_n,
    input wire sd_ras_n,
    input wire sd_cas_n,
    input wire sd_we_n,
    input wire [`SDCS_PINS-1:0] sd_addr,
    input wire [`SDCS_PINS-1:0] sd_addr_oe,
    input wire [3:0] sd_be_n
);
    wire [2:0] cmd = {sd_ras_n, sd_cas_n, sd_we_n};
    wire on = (sd_cs_n != 4'hf);
    wire is_act = on && cmd == `SDCS_CMD_ACT;
    wire is_rw = on && (cmd == `SDCS_CMD_RD || cmd == `SDCS_CMD_WR);
    wire is_rd = on && cmd == `SDCS_CMD_RD;
    wire is_wr = on && cmd == `SDCS_CMD_WR;
    wire is_pre = on && cmd == `SDCS_CMD_PRE;
    wire is_ref = on && cmd == `SDCS_CMD_REF;
    wire is_mrs = on && cmd == `SDCS_CMD_MRS;
    reg closed_q;
    reg bank_q;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // Cleared at reset so a refresh with no close first is caught
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            closed_q <= 1'b0;
            bank_q <= 1'b0;
        end else begin
            if (is_pre)
                closed_q <= 1'b1;
            else if (is_act)
                closed_q <= 1'b0;
            if (is_act)
                bank_q <= sd_addr[11];
        end
    end
    a_rw_no_autopre:
        assert property (is_rw |-> !sd_addr[10]) else $error("auto precharge requested");
    a_rw_bank_kept:
        assert property (is_rw |-> sd_addr[11] == bank_q) else $error("bank bit changed");
    a_ref_closed_first:
        assert property (is_ref |-> closed_q) else $error("refresh without close");
    a_ref_spacing:
        assert property (is_ref |=> !(is_act || is_mrs || is_ref) [*2]) else $error("refresh spacing");
    a_act_to_rw:
        assert property (is_act |=> !is_rw [*4]) else $error("activate to rw spacing");
    a_close_to_act:
        assert property (is_pre |=> !(is_act || is_mrs || is_ref) [*2]) else $error("close spacing");
    a_row_open_min:
        assert property (is_act |=> !is_pre [*3]) else $error("row closed early");
    a_mode_value:
        assert property (is_mrs |-> sd_addr == `SDCS_MRS_CL3 || sd_addr == `SDCS_MRS_CL2)
            else $error("bad mode value");
    a_read_latency:
        assert property (is_rd |-> ##[4:7] rd_valid) else $error("read data late");
    a_act_rows_driven:
        assert property (is_act |-> &sd_addr_oe[10:0] && !sd_addr_oe[`SDCS_PINS-1]) else $error("activate pins wrong");
    a_mask_before_wr:
        assert property (is_wr |-> $past(sd_be_n) == 4'hf) else $error("write without mask hold");
endmodule // sdcs_properties
bind sdcs_top sdcs_properties u_props (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .rd_valid(rd_valid),
    .sd_cs_n(sd_cs_n),
    .sd_ras_n(sd_ras_n),
    .sd_cas_n(sd_cas_n),
    .sd_we_n(sd_we_n),
    .sd_addr(sd_addr),
    .sd_addr_oe(sd_addr_oe),
    .sd_be_n(sd_be_n)
);

// ---- tb/sdcs_mem_model.sv ----
`timescale 1ns/10ps
`include "sdcs_consts.vh"
module sdcs_mem_model (
    // Pins
    input wire ref_clk,
    input wire [3:0] cs_n,
    input wire [2:0] cmd,
    input wire [19:0] addr,
    input wire [31:0] dq_o,
    input wire dq_oe,
    output reg [31:0] dq_i,
    // Observation
    output reg [19:0] mode_q,
    output reg [31:0] wr_q,
    output reg [7:0] act_cnt,
    output reg [7:0] ref_cnt,
    output reg bad_ref
);
    reg [10:0] row_q;
    reg [7:0] col_q;
    reg [1:0] due_q;
    reg [2:0] left_q;
    wire sel = (cs_n != 4'hf);
    initial begin
        {dq_i, mode_q, wr_q, act_cnt, ref_cnt, bad_ref} = 0;
        {row_q, col_q, due_q, left_q} = 0;
    end
    // Idle data lines toggle so a stale word shows only on alternate cycles
    always @(posedge ref_clk) begin
        if (sel && cmd == `SDCS_CMD_ACT) begin
            row_q <= addr[10:0];
            act_cnt <= act_cnt + 8'd1;
        end
        if (sel && cmd == `SDCS_CMD_MRS)
            mode_q <= addr;
        if (sel && cmd == `SDCS_CMD_REF) begin
            ref_cnt <= ref_cnt + 8'd1;
            if (cs_n !== 4'b1010)
                bad_ref <= 1'b1;
        end
        if (sel && cmd == `SDCS_CMD_WR && dq_oe)
            wr_q <= dq_o;
        if (sel && cmd == `SDCS_CMD_RD) begin
            col_q <= addr[7:0];
            due_q <= {1'b0, mode_q[4]};
            left_q <= 3'd4;
            dq_i <= ~dq_i;
        end else if (left_q != 3'd0 && due_q != 2'd0) begin
            due_q <= due_q - 2'd1;
            dq_i <= ~dq_i;
        end else if (left_q != 3'd0) begin
            dq_i <= {1'b1, row_q, 12'h000, col_q};
            col_q <= col_q + 8'd1;
            left_q <= left_q - 3'd1;
        end else begin
            dq_i <= ~dq_i;
        end
    end
endmodule // sdcs_mem_model

// ---- tb/sdcs_top_test.sv ----
`timescale 1ns/10ps
`include "sdcs_consts.vh"
module sdcs_top_test;
    reg ref_clk = 1'b0;
    reg nrst = 1'b0;
    reg hsel = 1'b0, hwrite = 1'b0, req_valid = 1'b0, req_write = 1'b0;
    reg [1:0] htrans = 2'b00;
    reg [31:0] haddr = 32'h0, hwdata = 32'h0, req_addr = 32'h0, req_wdata = 32'h0;
    wire hreadyout, hresp, req_ready, rd_valid, ras_n, cas_n, we_n, dq_oe, bad_ref;
    wire [31:0] hrdata, rd_data, dq_o, dq_i, wr_q;
    wire [3:0] cs_n;
    wire [19:0] sd_addr, mode_q;
    wire [7:0] act_cnt, ref_cnt;
    integer n_errors = 0, cmp_count = 0, cyc = 0;
    always #12.5 ref_clk = ~ref_clk;
    sdcs_top dut (.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .req_valid(req_valid), .req_write(req_write), .req_region(2'b00),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready), .rd_valid(rd_valid),
        .rd_data(rd_data), .sd_cs_n(cs_n), .sd_ras_n(ras_n), .sd_cas_n(cas_n), .sd_we_n(we_n),
        .sd_addr(sd_addr), .sd_addr_oe(), .sd_be_n(), .sd_dq_o(dq_o), .sd_dq_oe(dq_oe), .sd_dq_i(dq_i));
    sdcs_mem_model u_mem (.ref_clk(ref_clk), .cs_n(cs_n), .cmd({ras_n, cas_n, we_n}), .addr(sd_addr),
        .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i), .mode_q(mode_q), .wr_q(wr_q), .act_cnt(act_cnt),
        .ref_cnt(ref_cnt), .bad_ref(bad_ref));
    task wrap_up;
        begin
            if (n_errors == 0 && cmp_count > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    // Whole run needs about a thousand cycles
    always @(posedge ref_clk) begin
        cyc = cyc + 1;
        if (cyc == 10000) begin
            n_errors = n_errors + 1;
            wrap_up;
        end
    end
    task chk(input [31:0] got, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("BAD %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task ahb(input w, input [31:0] a, input [31:0] d, output [31:0] r);
        begin
            @(posedge ref_clk);
            hsel <= 1'b1;
            htrans <= 2'b10;
            haddr <= a;
            hwrite <= w;
            do @(posedge ref_clk); while (hreadyout !== 1'b1);
            hsel <= 1'b0;
            htrans <= 2'b00;
            hwdata <= d;
            do @(posedge ref_clk); while (hreadyout !== 1'b1);
            r = hrdata;
            chk({31'h0, hresp}, 32'h0);
        end
    endtask
    task req(input w, input [31:0] a, input [31:0] d);
        begin
            @(posedge ref_clk);
            req_valid <= 1'b1;
            req_write <= w;
            req_addr <= a;
            req_wdata <= d;
            do @(posedge ref_clk); while (req_ready !== 1'b1);
            req_valid <= 1'b0;
        end
    endtask
    // 32-bit bus, 8 columns: row from bit 10, column from bit 2
    task sd_read(input [31:0] a);
        begin
            req(1'b0, a, 32'h0);
            do @(posedge ref_clk); while (rd_valid !== 1'b1);
            chk(rd_data, {1'b1, a[20:10], 12'h000, a[9:2]});
        end
    endtask
    task t_regs;
        reg [31:0] r;
        integer i;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                ahb(1'b0, 4 * i, 32'h0, r);
                chk(r, i == 0 ? `SDCS_CTL_RST : i == 1 ? `SDCS_TIM_RST : i == 2 ? `SDCS_EXT_RST : `SDCS_SPC_RST);
            end
            ahb(1'b1, 32'h20, 32'hffff_ffff, r);
            ahb(1'b0, 32'h20, 32'h0, r);
            chk(r, 32'h0);
            ahb(1'b1, `SDCS_OFF_SPC, 32'h0010_2410, r);
            ahb(1'b0, `SDCS_OFF_SPC, 32'h0, r);
            chk(r, 32'h0010_2410);
        end
    endtask
    task t_mode(input [31:0] cas_latency_select);
        reg [31:0] r;
        integer k;
        begin
            ahb(1'b1, `SDCS_OFF_CTL, 32'h2b00 | (cas_latency_select << 1), r);
            r = 32'h4000;
            for (k = 0; k < 50 && r[14]; k = k + 1)
                ahb(1'b0, `SDCS_OFF_STAT, 32'h0, r);
            chk({31'h0, r[14]}, 32'h0);
            chk({12'h0, mode_q}, cas_latency_select ? 32'h32 : 32'h22);
            ahb(1'b0, `SDCS_OFF_CTL, 32'h0, r);
            chk(r, 32'h0b00 | (cas_latency_select << 1));
        end
    endtask
    task t_read;
        reg [7:0] a0;
        begin
            sd_read(32'h0012_3450);
            a0 = act_cnt;
            repeat (60) @(posedge ref_clk);
            sd_read(32'h0012_3454);
            sd_read(32'h0012_3458);
            chk({24'h0, act_cnt}, {24'h0, a0});
            sd_read(32'h0032_3450);
            chk({24'h0, act_cnt}, {24'h0, a0 + 8'd1});
            req(1'b1, 32'h0032_3460, 32'hc0de_0a5b);
            repeat (2) @(posedge ref_clk);
            chk(wr_q, 32'hc0de_0a5b);
            sd_read(32'h0032_3464);
        end
    endtask
    task t_refresh;
        reg [31:0] r;
        reg [7:0] r0;
        reg [7:0] n;
        begin
            r0 = ref_cnt;
            repeat (300) @(posedge ref_clk);
            chk({24'h0, ref_cnt}, {24'h0, r0});
            ahb(1'b1, `SDCS_OFF_TIM, 32'h101f, r);
            ahb(1'b1, `SDCS_OFF_CTL, 32'h0b03, r);
            r0 = ref_cnt;
            repeat (320) @(posedge ref_clk);
            n = ref_cnt - r0;
            // Ten expiries with one extra each; window edges may cut a pair
            chk({31'h0, n >= 8'd17 && n <= 8'd22}, 32'h1);
            chk({31'h0, bad_ref}, 32'h0);
            sd_read(32'h0012_3450);
            sd_read(32'h0052_3450);
        end
    endtask
    // 16-bit bus, 9 columns, 13 rows, two bank bits; address bit 25 lies above the page
    task t_geom;
        reg [31:0] r;
        reg [7:0] a0;
        begin
            ahb(1'b1, `SDCS_OFF_CTL, 32'h0aee, r);
            req(1'b0, 32'h0012_3450, 32'h0);
            do @(posedge ref_clk); while (rd_valid !== 1'b1);
            chk(rd_data, {1'b1, 11'h48d, 12'h000, 8'h28});
            a0 = act_cnt;
            req(1'b0, 32'h0212_3450, 32'h0);
            do @(posedge ref_clk); while (rd_valid !== 1'b1);
            chk({24'h0, act_cnt}, {24'h0, a0});
            chk(rd_data, {1'b1, 11'h48d, 12'h000, 8'h28});
        end
    endtask
    initial begin
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        t_regs;
        t_mode(0);
        t_mode(1);
        t_read;
        t_refresh;
        t_geom;
        wrap_up;
    end
endmodule // sdcs_top_test
